// file: bench/lcs_sensor_model.sv
// Behavioural line sensor that sends one line of pixels per request.
`timescale 1ns/10ps
`default_nettype none
module lcs_sensor_model (
    input  wire logic        pclk,
    input  wire logic        go,
    input  wire logic [4:0]  npix,
    input  wire logic        pixel_ready,
    output var  logic        line_start_pulse,
    output var  logic        pixel_valid,
    output wire logic [15:0] red_sensor_input,
    output wire logic [15:0] green_sensor_input,
    output wire logic [15:0] blue_sensor_input
);
    // ****************************************
    // Line source
    // ****************************************
    logic [15:0] idx = 16'h0;
    logic [15:0] junk = 16'h0;
    int          i;
    // Idle data churns so that a stale pixel can never pass as a good one.
    always @(posedge pclk) junk <= junk + 16'h1357;
    assign red_sensor_input   = pixel_valid ? 16'h1000 + idx : junk;
    assign green_sensor_input = pixel_valid ? 16'h2000 + idx : ~junk;
    assign blue_sensor_input  = pixel_valid ? 16'h3000 + idx : junk ^ 16'hA5A5;
    initial
    begin
        line_start_pulse = 1'b0;
        pixel_valid = 1'b0;
        forever
        begin
            @(posedge pclk);
            if (go === 1'b1)
            begin
                line_start_pulse <= 1'b1;
                @(posedge pclk);
                line_start_pulse <= 1'b0;
                for (i = 0; i < npix; i++)
                begin
                    // At 30 MHz a pixel comes at most every 9 cycles.
                    repeat (9) @(posedge pclk);
                    idx <= i[15:0];
                    pixel_valid <= 1'b1;
                    do @(posedge pclk); while (pixel_ready !== 1'b1);
                    pixel_valid <= 1'b0;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: bench/lcs_seq_sva.sv
// Port checks for the line sequencer.
`timescale 1ns/10ps
`default_nettype none
module lcs_seq_sva #(
    parameter PIX_W = 16
) (
    input wire logic             pclk,
    input wire logic             presetn,
    input wire logic             psel,
    input wire logic             penable,
    input wire logic [31:0]      prdata,
    input wire logic             pready,
    input wire logic             pslverr,
    input wire logic             line_start_pulse,
    input wire logic             pixel_valid,
    input wire logic             pixel_ready,
    input wire logic             out_valid,
    input wire logic             out_ready,
    input wire logic [PIX_W-1:0] out_data,
    input wire logic [1:0]       out_channel,
    input wire logic [8:0]       dac_offset,
    input wire logic [7:0]       pga_gain,
    input wire logic             line_active
);
    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    acc_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer one cycle after access");
    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_rdy_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    coef_hold_a: assert property (
        !$stable({dac_offset, pga_gain}) |-> $past(line_start_pulse))
        else $error("coefficients moved off a line start");
    chan_hold_a: assert property (
        !$stable(out_channel) |-> $past(line_start_pulse, 2))
        else $error("channel moved off a line start");
    act_rise_a: assert property (
        $rose(line_active) |-> $past(line_start_pulse))
        else $error("line went active without a line start");
    no_line_a: assert property (!line_active |-> !pixel_ready)
        else $error("pixels taken outside a line");
    out_stall_a: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("stalled output changed");
    line_c: cover property (line_start_pulse && line_active);
    err_c: cover property (pslverr);
    stall_c: cover property (pixel_valid && !pixel_ready && line_active);
endmodule
`default_nettype wire

// file: bench/line_sequential_channel_sequencer_bench.sv
// Self-checking bench for the line sequencer.
`timescale 1ns/10ps
`default_nettype none
`include "lcs_regs.vh"
module line_sequential_channel_sequencer_bench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        line_start_pulse, pixel_valid, pixel_ready, out_valid;
    logic        out_ready, line_active, go, err, refused;
    logic [15:0] red_sensor_input, green_sensor_input, blue_sensor_input;
    logic [15:0] out_data;
    logic [15:0] rxq[$];
    logic [1:0]  out_channel;
    logic [8:0]  dac_offset;
    logic [7:0]  pga_gain;
    logic [4:0]  npix;
    int          fail_count, n_compared;
    lcs_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .line_start_pulse(line_start_pulse), .pixel_valid(pixel_valid),
        .pixel_ready(pixel_ready), .red_sensor_input(red_sensor_input),
        .green_sensor_input(green_sensor_input),
        .blue_sensor_input(blue_sensor_input), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data),
        .out_channel(out_channel), .dac_offset(dac_offset),
        .pga_gain(pga_gain), .line_active(line_active));
    lcs_sensor_model sen_u (.pclk(pclk), .go(go), .npix(npix),
        .pixel_ready(pixel_ready), .line_start_pulse(line_start_pulse),
        .pixel_valid(pixel_valid), .red_sensor_input(red_sensor_input),
        .green_sensor_input(green_sensor_input),
        .blue_sensor_input(blue_sensor_input));
    // ****************************************
    // Tasks
    // ****************************************
    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (out_valid === 1'b1 && out_ready === 1'b1)
            rxq.push_back(out_data);
        if (pixel_valid && !pixel_ready && !out_ready)
            refused <= 1'b1;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
    begin
        n_compared++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    task test_done;
    begin
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
    endtask
    function automatic logic [31:0] coef(input int k);
        return (32'hA0 + k) << 16 | (32'h100 + k);
    endfunction
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
    begin
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        if (pready !== 1'b1)
        begin
            chk(32'h0, 32'h1);
            test_done;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    end
    endtask
    // Sends one line and checks set, channel and every pixel that came out.
    task line(input int n, input logic [1:0] ch, input int s, input logic st);
        int k;
    begin
        rxq.delete();
        refused = 1'b0;
        out_ready <= !st;
        npix <= n[4:0];
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        for (k = 0; st && refused !== 1'b1 && k < 4000; k++) @(posedge pclk);
        if (st)
            out_ready <= 1'b1;
        for (k = 0; rxq.size() < n && k < 4000; k++) @(posedge pclk);
        if (rxq.size() < n)
        begin
            chk(32'h0, 32'h1);
            test_done;
        end
        if (st)
            chk(refused, 1'b1);
        chk(dac_offset, 32'h100 + s);
        chk(pga_gain, 32'hA0 + s);
        chk(out_channel, ch);
        chk(line_active, 1'b1);
        for (k = 0; k < n; k++)
            chk(rxq[k], 32'h1000 * (ch + 32'h1) + k);
    end
    endtask
    task t_regs;
        int k;
    begin
        apb(1'b0, `LCS_CTRL_ADDR, 32'h0);
        chk(rd, `LCS_CTRL_RESET);
        apb(1'b0, `LCS_ORDER_ADDR, 32'h0);
        chk(rd, `LCS_ORDER_RESET);
        apb(1'b0, 12'h100, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        for (k = 0; k < 5; k++)
            apb(1'b1, `LCS_COEF0_ADDR + 12'(4 * k), coef(k));
        apb(1'b0, 12'h020, 32'h0);
        chk(rd, coef(4));
        $display("register test done");
    end
    endtask
    task t_single(input logic rev);
        int i;
    begin
        apb(1'b1, `LCS_CTRL_ADDR, 32'h161 | {27'h0, rev, 4'h0});
        for (i = 0; i < 4; i++)
            line(2, 2'd0, rev ? 2 - i % 3 : i % 3, 1'b0);
        apb(1'b0, `LCS_STATUS_ADDR, 32'h0);
        chk(rd, rev ? 32'h20 : 32'h0);
        $display("single input test done");
    end
    endtask
    task t_mono;
    begin
        apb(1'b1, `LCS_CTRL_ADDR, 32'h165);
        line(2, 2'd1, 0, 1'b0);
        line(2, 2'd1, 0, 1'b0);
        apb(1'b1, `LCS_CTRL_ADDR, 32'h169);
        line(12, 2'd2, 0, 1'b1);
        apb(1'b1, `LCS_CTRL_ADDR, 32'h12D);
        line(2, 2'd0, 0, 1'b0);
        $display("mono and stall test done");
    end
    endtask
    task t_three(input logic [31:0] ord);
        int i;
    begin
        apb(1'b1, `LCS_ORDER_ADDR, ord);
        apb(1'b1, `LCS_CTRL_ADDR, 32'h103);
        chk(line_active, 1'b0);
        for (i = 0; i < 6; i++)
            line(2, ord[2*(i%3)+:2], ord[2*(i%3)+:2], 1'b0);
        $display("three input test done");
    end
    endtask
    // Mid-run reset must drop the line and bring back the control register default.
    task t_reset;
    begin
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk({line_active, pixel_ready, out_valid, dac_offset, pga_gain},
            32'h0);
        presetn <= 1'b1;
        apb(1'b0, `LCS_CTRL_ADDR, 32'h0);
        chk(rd, `LCS_CTRL_RESET);
        $display("reset test done");
    end
    endtask
    initial
    begin
        {psel, penable, pwrite, go, out_ready, refused, err} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        npix = 5'h0;
        presetn = 1'b0;
        fail_count = 0;
        n_compared = 0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs;
        t_single(1'b0);
        t_single(1'b1);
        t_mono;
        t_three(32'h24);
        t_three(32'h06);
        t_reset;
        test_done;
    end
endmodule
bind lcs_sequencer lcs_seq_sva #(.PIX_W(PIX_W)) chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_start_pulse(line_start_pulse),
    .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_channel(out_channel), .dac_offset(dac_offset),
    .pga_gain(pga_gain), .line_active(line_active));
`default_nettype wire

// file: common/lcs_regs.vh
// Register offsets, field layouts, reset values and timing for the sequencer.
`ifndef LCS_REGS_VH
`define LCS_REGS_VH

// Register byte offsets on APB.
`define LCS_CTRL_ADDR     12'h000
`define LCS_ORDER_ADDR    12'h004
`define LCS_COEF0_ADDR    12'h010
`define LCS_STATUS_ADDR   12'h030
`define LCS_COEF_STRIDE   12'h004

// Control register fields.
`define LCS_CTRL_EN_BIT   0
`define LCS_CTRL_MODE_BIT 1
`define LCS_CTRL_SEL_LSB  2
`define LCS_CTRL_REV_BIT  4
`define LCS_CTRL_NCOL_LSB 5
`define LCS_CTRL_RST_BIT  8
`define LCS_CTRL_RESET    32'h00000020

// Channel order register: three 2-bit channel codes, first in low bits.
`define LCS_ORDER_RESET   32'h00000024

// Channel codes.
`define LCS_CH_RED        2'h0
`define LCS_CH_GREEN      2'h1
`define LCS_CH_BLUE       2'h2

// Coefficient word: offset in [8:0], gain in [23:16].
`define LCS_COEF_RESET    32'h00000000
`define LCS_MAX_COLORS    5

// Input pixel clock limit for line modes.
`define LCS_PIX_MAX_MHZ   30
`define LCS_PCLK_MHZ      250

`endif

// file: rtl/lcs_fifo.v
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none

module lcs_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output reg  [WIDTH-1:0] out_data
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    wire [AW-1:0]   rd_nx;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign rd_nx     = !pop ? rd_q :
                       (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                      : rd_q + 1'b1;

    always @(posedge pclk)
    begin
        if (push)
            mem[wr_q] <= in_data;
    end

    // Read data is registered so the head word is always presented.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_q     <= {AW{1'b0}};
            rd_q     <= {AW{1'b0}};
            cnt_q    <= {(AW+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                       : wr_q + 1'b1;
            rd_q <= rd_nx;
            if (push && !pop)
                cnt_q <= cnt_q + 1'b1;
            else if (pop && !push)
                cnt_q <= cnt_q - 1'b1;
        end
    end

    // The head word leaves a register; a push into an empty or emptying FIFO bypasses
    // the memory, which would still hold the stale word at that edge.
    always @(posedge pclk)
    begin
        if (push && (wr_q == rd_nx))
            out_data <= in_data;
        else
            out_data <= mem[rd_nx];
    end

endmodule

`default_nettype wire

// file: rtl/lcs_sequencer.v
// Line-sequential channel and coefficient sequencer with APB registers.
`timescale 1ns/10ps
`default_nettype none
`include "lcs_regs.vh"


module lcs_sequencer #(
    parameter PIX_W  = 16,
    parameter FDEPTH = 8,
    parameter FAW    = 3
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             psel,
    input  wire             penable,
    input  wire             pwrite,
    input  wire [11:0]      paddr,
    input  wire [31:0]      pwdata,
    output reg  [31:0]      prdata,
    output reg              pready,
    output reg              pslverr,
    input  wire             line_start_pulse,
    input  wire             pixel_valid,
    output reg              pixel_ready,
    input  wire [PIX_W-1:0] red_sensor_input,
    input  wire [PIX_W-1:0] green_sensor_input,
    input  wire [PIX_W-1:0] blue_sensor_input,
    output reg              out_valid,
    input  wire             out_ready,
    output reg  [PIX_W-1:0] out_data,
    output reg  [1:0]       out_channel,
    output reg  [8:0]       dac_offset,
    output reg  [7:0]       pga_gain,
    output reg              line_active
);

    // ****************************************************************
    // Register file
    // ****************************************************************
    reg  [31:0] ctrl_q;
    reg  [31:0] order_q;
    reg  [31:0] coef_q [0:`LCS_MAX_COLORS-1];
    reg  [1:0]  ch_q;
    reg  [2:0]  col_q;
    reg         armed_q;
    reg  [31:0] rdata_d;
    reg         err_d;
    wire        acc;
    wire        en;
    wire        mode3;
    wire        rev;
    wire [1:0]  sel;
    wire [2:0]  ncol;
    wire        restart;
    wire [`LCS_MAX_COLORS-1:0] coef_we;
    integer     i;
    genvar      g;

    assign acc   = psel & penable & ~pready;
    assign en    = ctrl_q[`LCS_CTRL_EN_BIT];
    assign mode3 = ctrl_q[`LCS_CTRL_MODE_BIT];
    assign sel   = ctrl_q[`LCS_CTRL_SEL_LSB+1:`LCS_CTRL_SEL_LSB];
    assign rev   = ctrl_q[`LCS_CTRL_REV_BIT];
    assign ncol  = ctrl_q[`LCS_CTRL_NCOL_LSB+2:`LCS_CTRL_NCOL_LSB];

    // ****************************************************************
    // Coefficient write strobes
    // ****************************************************************
    // One strobe per word keeps the address compare out of the write loop.
    generate
        for (g = 0; g < `LCS_MAX_COLORS; g = g + 1)
        begin : g_coef_we
            localparam integer ofs = `LCS_COEF0_ADDR + g * `LCS_COEF_STRIDE;
            assign coef_we[g] = acc & pwrite & (paddr == ofs[11:0]);
        end
    endgenerate

    // Index of a coefficient word, or 7 when the address is none.
    function [2:0] coef_idx;
        input [11:0] a;
        integer      k;
        begin
            coef_idx = 3'h7;
            for (k = 0; k < `LCS_MAX_COLORS; k = k + 1)
                if (a == `LCS_COEF0_ADDR + k[11:0] * `LCS_COEF_STRIDE)
                    coef_idx = k[2:0];
        end
    endfunction

    // Channel code held in one slot of the order register.
    function [1:0] order_ch;
        input [31:0] o;
        input [1:0]  slot;
        begin
            case (slot)
                2'h0:    order_ch = o[1:0];
                2'h1:    order_ch = o[3:2];
                default: order_ch = o[5:4];
            endcase
        end
    endfunction

    always @*
    begin
        rdata_d = 32'h00000000;
        err_d   = 1'b0;
        if (paddr == `LCS_CTRL_ADDR)
            rdata_d = {23'h000000, ctrl_q[8:0]};
        else if (paddr == `LCS_ORDER_ADDR)
            rdata_d = {26'h0000000, order_q[5:0]};
        else if (paddr == `LCS_STATUS_ADDR)
            rdata_d = {24'h000000, armed_q, col_q, 2'h0, out_channel};
        else if (coef_idx(paddr) != 3'h7)
            rdata_d = coef_q[coef_idx(paddr)];
        else
            err_d = 1'b1;
    end

    // One wait state: pready rises in the second access cycle.
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q  <= `LCS_CTRL_RESET;
            order_q <= `LCS_ORDER_RESET;
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
            for (i = 0; i < `LCS_MAX_COLORS; i = i + 1)
                coef_q[i] <= `LCS_COEF_RESET;
        end
        else
        begin
            pready  <= acc;
            pslverr <= acc & err_d;
            prdata  <= (acc & ~pwrite) ? rdata_d : 32'h00000000;
            // Soft restart is self-clearing.
            ctrl_q[`LCS_CTRL_RST_BIT] <= 1'b0;
            if (acc && pwrite && !err_d)
            begin
                if (paddr == `LCS_CTRL_ADDR)
                    ctrl_q <= {23'h000000, pwdata[8:0]};
                else if (paddr == `LCS_ORDER_ADDR)
                    order_q <= {26'h0000000, pwdata[5:0]};
            end
            for (i = 0; i < `LCS_MAX_COLORS; i = i + 1)
                if (coef_we[i])
                    coef_q[i] <= pwdata;
        end
    end

    // ****************************************************************
    // Line sequencer
    // ****************************************************************
    // Mode change or soft restart rearms so the next pulse picks the first.
    reg        mode_q;
    reg [2:0]  ncol_q;
    wire [2:0] last;
    wire       mono;
    wire [2:0] first_col;
    wire [2:0] next_col;
    wire [1:0] next_slot;
    reg  [1:0] slot_q;

    assign restart   = ~en | ctrl_q[`LCS_CTRL_RST_BIT] | (mode_q != mode3)
                     | (ncol_q != ncol);
    assign mono      = (sel != `LCS_CH_RED) | (ncol < 3'h2);
    assign last      = mono ? 3'h0 :
                       (ncol > 3'h5) ? 3'h4 : ncol - 3'h1;
    assign first_col = rev ? last : 3'h0;
    assign next_col  = rev ? ((col_q == 3'h0) ? last : col_q - 3'h1)
                           : ((col_q >= last) ? 3'h0 : col_q + 3'h1);
    assign next_slot = (slot_q == 2'h2) ? 2'h0 : slot_q + 2'h1;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_q  <= 1'b0;
            ncol_q  <= 3'h1;
            armed_q <= 1'b1;
            col_q   <= 3'h0;
            slot_q  <= 2'h0;
            ch_q    <= `LCS_CH_RED;
            line_active <= 1'b0;
            dac_offset  <= 9'h000;
            pga_gain    <= 8'h00;
        end
        else
        begin
            mode_q <= mode3;
            ncol_q <= ncol;
            if (restart)
            begin
                armed_q     <= 1'b1;
                line_active <= 1'b0;
            end
            else if (line_start_pulse)
            begin
                armed_q     <= 1'b0;
                line_active <= 1'b1;
                if (mode3)
                begin
                    slot_q <= armed_q ? 2'h0 : next_slot;
                    ch_q   <= order_ch(order_q,
                                       armed_q ? 2'h0 : next_slot);
                    // Three-input mode uses slots 0..2 for per-channel sets.
                    dac_offset <= coef_q[order_ch(order_q,
                                  armed_q ? 2'h0 : next_slot)][8:0];
                    pga_gain   <= coef_q[order_ch(order_q,
                                  armed_q ? 2'h0 : next_slot)][23:16];
                end
                else
                begin
                    col_q      <= armed_q ? first_col : next_col;
                    ch_q       <= (sel == 2'h3) ? `LCS_CH_RED : sel;
                    dac_offset <= coef_q[armed_q ? first_col
                                                 : next_col][8:0];
                    pga_gain   <= coef_q[armed_q ? first_col
                                                 : next_col][23:16];
                end
            end
        end
    end

    // ****************************************************************
    // Pixel path
    // ****************************************************************
    // Converter rate equals pixel rate; one pixel per accepted beat.
    reg  [PIX_W-1:0] pix_d;
    reg  [FAW:0]     occ_d;
    reg  [FAW:0]     occ_q;
    wire             f_ovalid;
    wire [PIX_W-1:0] f_odata;
    wire             take;
    wire             push;
    wire             pop;
    wire             act_d;

    assign take  = ~out_valid | out_ready;
    assign push  = pixel_valid & pixel_ready;
    assign pop   = f_ovalid & take;
    assign act_d = restart ? 1'b0 : (line_start_pulse | line_active);

    // ****************************************************************
    // Input handshake
    // ****************************************************************
    // Occupancy shadows the FIFO count so that ready can leave a flop
    // and still say exactly whether the next beat has room.
    always @*
    begin
        occ_d = occ_q;
        if (push && !pop)
            occ_d = occ_q + 1'b1;
        else if (pop && !push)
            occ_d = occ_q - 1'b1;
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            occ_q       <= {(FAW+1){1'b0}};
            pixel_ready <= 1'b0;
        end
        else
        begin
            occ_q       <= occ_d;
            pixel_ready <= act_d & (occ_d != FDEPTH[FAW:0]);
        end
    end

    always @*
    begin
        case (ch_q)
            `LCS_CH_GREEN: pix_d = green_sensor_input;
            `LCS_CH_BLUE:  pix_d = blue_sensor_input;
            default:       pix_d = red_sensor_input;
        endcase
    end

    lcs_fifo #(
        .WIDTH (PIX_W),
        .DEPTH (FDEPTH),
        .AW    (FAW)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (push),
        .in_ready  (),
        .in_data   (pix_d),
        .out_valid (f_ovalid),
        .out_ready (take),
        .out_data  (f_odata)
    );

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_valid   <= 1'b0;
            out_data    <= {PIX_W{1'b0}};
            out_channel <= `LCS_CH_RED;
        end
        else
        begin
            out_channel <= ch_q;
            if (take)
            begin
                out_valid <= f_ovalid;
                if (f_ovalid)
                    out_data <= f_odata;
            end
        end
    end

endmodule

`default_nettype wire
